// ==== verilog/clds_map.vh ====
// register map, field positions and timing constants of the charger, load and short detector
`ifndef CLDS_MAP_VH
`define CLDS_MAP_VH
// ============================================================
// Overview of operation
// - low charger comparator runs and pulls sense pin up while its run bit is 1.
// - low charger comparator rising edge asserts interrupt when its enable is 1.
// - low charger flag sets on rising edge, clears on written 0, held 0 when disabled.
// - low charger output is 1 when charger absent, forced 0 when stopped, read only.
// - high charger comparator runs and pulls sense pin up while its run bit is 1.
// - high charger comparator rising edge asserts interrupt when its enable is 1.
// - high charger flag sets on rising edge, clears on written 0, held 0 when disabled.
// - high charger output is 1 above three quarters supply, forced 0 when stopped.
// - short run bit starts or stops short detection; stopped after reset.
// - confirmed short asserts interrupt when short interrupt enable is 1.
// - short flag records confirmed short, clears on written 0, held 0 when disabled.
// - short output shows short comparator, held 0 when stopped, read only.
// - short output rising starts delay; at its end flag sets and both fets turn off.
// - short output falling before delay end aborts delay and resets it, no action.
// - delay in microseconds is capacitance in nanofarads times 100, a parameter.
// - load comparator runs and pulls load pin down while its run bit is 1.
// - load open rising edge asserts interrupt when load interrupt enable is 1.
// - load flag sets on rising edge, clears on written 0, held 0 when disabled.
// - load open output is 1 when load absent, held 0 when stopped, read only.
// - discharge fet is switched off by a short and never switched on again here.
// - read only status bit shows whether interrupt pin is asserted.
// ============================================================
// register offsets
`define CLDS_CHG_CTRL_ADDR   8'h04
`define CLDS_LOAD_CTRL_ADDR  8'h05
`define CLDS_REG_RESET       8'h00
// ============================================================
// field positions, charger_sense_ctrl
`define CLDS_CHG_LOW_OUT     0
`define CLDS_CHG_LOW_FLAG    1
`define CLDS_CHG_LOW_EN      2
`define CLDS_CHG_LOW_RUN     3
`define CLDS_CHG_HIGH_OUT    4
`define CLDS_CHG_HIGH_FLAG   5
`define CLDS_CHG_HIGH_EN     6
`define CLDS_CHG_HIGH_RUN    7
// field positions, load_short_sense_ctrl
`define CLDS_LOAD_OUT        0
`define CLDS_LOAD_FLAG       1
`define CLDS_LOAD_EN         2
`define CLDS_LOAD_RUN        3
`define CLDS_SHORT_OUT       4
`define CLDS_SHORT_FLAG      5
`define CLDS_SHORT_EN        6
`define CLDS_SHORT_RUN       7
// ============================================================
// timing
`define CLDS_CLK_MHZ         100
`define CLDS_SC_US_PER_NF    100
`define CLDS_DELAY_CAP_NF    1
`endif

// ==== verilog/clds_short_delay.v ====
// short detection delay element: counts while the short persists
`timescale 1ns/1ns
module clds_short_delay #(
  parameter CNT_W  = 24,
  parameter CYCLES = 10000
) (
  mclk,
  rst,
  short_level,
  delay_done
);
  input  wire             mclk;
  input  wire             rst;
  input  wire             short_level;
  output reg              delay_done;

  localparam [CNT_W-1:0] LAST = CYCLES - 1;

  reg  [CNT_W-1:0]        count_reg;
  reg                     fired_reg;

  // ============================================================
  // counter
  // at most one pulse per short episode; a held short never fires twice
  always @(posedge mclk) begin
    if (rst) begin
      count_reg  <= {CNT_W{1'b0}};
      fired_reg  <= 1'b0;
      delay_done <= 1'b0;
    end else if (!short_level) begin
      count_reg  <= {CNT_W{1'b0}};
      fired_reg  <= 1'b0;
      delay_done <= 1'b0;
    end else if (!fired_reg && count_reg == LAST) begin
      fired_reg  <= 1'b1;
      delay_done <= 1'b1;
    end else begin
      delay_done <= 1'b0;
      if (!fired_reg)
        count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ==== verilog/clds_detect.v ====
// charger sense, load sense and short detection with interrupt flags
`timescale 1ns/1ns
`include "clds_map.vh"
module clds_detect #(
  parameter DELAY_CAP_NF = `CLDS_DELAY_CAP_NF,
  parameter DELAY_CNT_W  = 24,
  parameter SHORT_DELAY_CYCLES = DELAY_CAP_NF * `CLDS_SC_US_PER_NF * `CLDS_CLK_MHZ
) (
  mclk,
  rst,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  chg_low_cmp_raw,
  chg_high_cmp_raw,
  load_cmp_raw,
  short_cmp_raw,
  charger_pullup_en,
  load_pulldown_en,
  fet_off_pulse,
  irq_out_n,
  irq_pin_state
);
  input  wire             mclk;
  input  wire             rst;
  input  wire [7:0]       reg_addr;
  input  wire             reg_wr;
  input  wire             reg_rd;
  input  wire [7:0]       reg_wdata;
  output reg  [7:0]       reg_rdata;
  input  wire             chg_low_cmp_raw;
  input  wire             chg_high_cmp_raw;
  input  wire             load_cmp_raw;
  input  wire             short_cmp_raw;
  output wire             charger_pullup_en;
  output wire             load_pulldown_en;
  output wire             fet_off_pulse;
  output reg              irq_out_n;
  output wire             irq_pin_state;

  // ============================================================
  // pin synchronisers, two stages each
  reg  [3:0]              sync1_reg;
  reg  [3:0]              sync2_reg;
  always @(posedge mclk) begin
    if (rst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {short_cmp_raw, load_cmp_raw, chg_high_cmp_raw, chg_low_cmp_raw};
      sync2_reg <= sync1_reg;
    end
  end

  // ============================================================
  // control bits
  reg                     chg_low_cmp_run;
  reg                     chg_low_irq_en;
  reg                     chg_high_cmp_run;
  reg                     chg_high_irq_en;
  reg                     load_cmp_run;
  reg                     load_irq_en;
  reg                     short_det_run;
  reg                     short_irq_en;
  reg                     chg_low_irq_flag;
  reg                     chg_high_irq_flag;
  reg                     load_irq_flag;
  reg                     short_irq_flag;
  reg  [3:0]              prev_reg;

  wire wr_chg  = reg_wr && (reg_addr == `CLDS_CHG_CTRL_ADDR);
  wire wr_load = reg_wr && (reg_addr == `CLDS_LOAD_CTRL_ADDR);

  // ============================================================
  // comparator outputs, gated by run bits
  wire chg_low_cmp_out  = sync2_reg[0] & chg_low_cmp_run;
  wire chg_high_cmp_out = sync2_reg[1] & chg_high_cmp_run;
  wire load_open_out    = sync2_reg[2] & load_cmp_run;
  wire short_cmp_out    = sync2_reg[3] & short_det_run;
  wire [3:0] cmp_now = {short_cmp_out, load_open_out, chg_high_cmp_out, chg_low_cmp_out};
  wire [3:0] rise    = cmp_now & ~prev_reg;

  assign charger_pullup_en = chg_low_cmp_run | chg_high_cmp_run;
  assign load_pulldown_en  = load_cmp_run;

  wire short_confirmed;
  clds_short_delay #(
    .CNT_W  (DELAY_CNT_W),
    .CYCLES (SHORT_DELAY_CYCLES)
  ) u_delay (
    .mclk        (mclk),
    .rst         (rst),
    .short_level (short_cmp_out),
    .delay_done  (short_confirmed)
  );
  // pulse switches both fets off; nothing here turns them back on
  assign fet_off_pulse = short_confirmed;

  // ============================================================
  // flag update: set wins over a written 0, enable off holds 0
  function flag_next;
    input en_new;
    input set_ev;
    input cur;
    input wr;
    input wbit;
    begin
      flag_next = en_new & (set_ev | (cur & ~(wr & ~wbit)));
    end
  endfunction

  wire low_en_n   = wr_chg  ? reg_wdata[`CLDS_CHG_LOW_EN]  : chg_low_irq_en;
  wire high_en_n  = wr_chg  ? reg_wdata[`CLDS_CHG_HIGH_EN] : chg_high_irq_en;
  wire load_en_n  = wr_load ? reg_wdata[`CLDS_LOAD_EN]     : load_irq_en;
  wire short_en_n = wr_load ? reg_wdata[`CLDS_SHORT_EN]    : short_irq_en;

  always @(posedge mclk) begin
    if (rst) begin
      chg_low_cmp_run   <= 1'b0;
      chg_low_irq_en    <= 1'b0;
      chg_high_cmp_run  <= 1'b0;
      chg_high_irq_en   <= 1'b0;
      load_cmp_run      <= 1'b0;
      load_irq_en       <= 1'b0;
      short_det_run     <= 1'b0;
      short_irq_en      <= 1'b0;
      chg_low_irq_flag  <= 1'b0;
      chg_high_irq_flag <= 1'b0;
      load_irq_flag     <= 1'b0;
      short_irq_flag    <= 1'b0;
      prev_reg          <= 4'h0;
    end else begin
      prev_reg <= cmp_now;
      if (wr_chg) begin
        chg_low_cmp_run  <= reg_wdata[`CLDS_CHG_LOW_RUN];
        chg_high_cmp_run <= reg_wdata[`CLDS_CHG_HIGH_RUN];
      end
      if (wr_load) begin
        load_cmp_run  <= reg_wdata[`CLDS_LOAD_RUN];
        short_det_run <= reg_wdata[`CLDS_SHORT_RUN];
      end
      chg_low_irq_en  <= low_en_n;
      chg_high_irq_en <= high_en_n;
      load_irq_en     <= load_en_n;
      short_irq_en    <= short_en_n;
      chg_low_irq_flag  <= flag_next(low_en_n, rise[0], chg_low_irq_flag,
                                     wr_chg, reg_wdata[`CLDS_CHG_LOW_FLAG]);
      chg_high_irq_flag <= flag_next(high_en_n, rise[1], chg_high_irq_flag,
                                     wr_chg, reg_wdata[`CLDS_CHG_HIGH_FLAG]);
      load_irq_flag     <= flag_next(load_en_n, rise[2], load_irq_flag,
                                     wr_load, reg_wdata[`CLDS_LOAD_FLAG]);
      short_irq_flag    <= flag_next(short_en_n, short_confirmed, short_irq_flag,
                                     wr_load, reg_wdata[`CLDS_SHORT_FLAG]);
    end
  end

  // ============================================================
  // interrupt pin
  wire any_flag = chg_low_irq_flag | chg_high_irq_flag | load_irq_flag | short_irq_flag;
  always @(posedge mclk) begin
    if (rst)
      irq_out_n <= 1'b1;
    else
      irq_out_n <= ~any_flag;
  end
  assign irq_pin_state = ~irq_out_n;

  // ============================================================
  // read back, one cycle after the read strobe
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= `CLDS_REG_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        `CLDS_CHG_CTRL_ADDR:
          reg_rdata <= {chg_high_cmp_run, chg_high_irq_en, chg_high_irq_flag, chg_high_cmp_out,
                        chg_low_cmp_run, chg_low_irq_en, chg_low_irq_flag, chg_low_cmp_out};
        `CLDS_LOAD_CTRL_ADDR:
          reg_rdata <= {short_det_run, short_irq_en, short_irq_flag, short_cmp_out,
                        load_cmp_run, load_irq_en, load_irq_flag, load_open_out};
        default:
          reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// ==== verification/clds_mcu_model.sv ====
// controller model driving the detector register port
`timescale 1ns/1ns
module clds_mcu_model #(
  parameter SETTLE = 20
) (
  input  wire       mclk,
  output reg  [7:0] reg_addr,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata
);
  // ============================================================
  // bus cycles, k is {wr, rd}; strobes stay up until the next call
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
  task acc(input [1:0] k, input [7:0] a, input [7:0] d);
    begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {k, a, d};
      @(posedge mclk);
      #1;
    end
  endtask
  task idle(input integer n);
    begin
      acc(2'b00, reg_addr, 8'h00);
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  // settle time shortened so the run stays brief
  task arm(input [7:0] a, input [7:0] run, input [7:0] en);
    begin
      acc(2'b10, a, run);
      idle(SETTLE);
      acc(2'b10, a, run | en);
      idle(0);
    end
  endtask
endmodule

// ==== verification/clds_detect_properties.sv ====
// port checker for the charger, load and short detector
`timescale 1ns/1ns
module clds_detect_properties (
  input  wire       mclk,
  input  wire       rst,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  input  wire [7:0] reg_rdata,
  input  wire       chg_low_cmp_raw,
  input  wire       chg_high_cmp_raw,
  input  wire       load_cmp_raw,
  input  wire       short_cmp_raw,
  input  wire       charger_pullup_en,
  input  wire       load_pulldown_en,
  input  wire       fet_off_pulse,
  input  wire       irq_out_n,
  input  wire       irq_pin_state
);
  // ============================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  pull_up_a: assert property (
    reg_wr && reg_addr == 8'h04 |=> charger_pullup_en == ($past(reg_wdata[7]) | $past(reg_wdata[3])))
    else $error("charger pull-up does not follow run bits");
  pull_down_a: assert property (
    reg_wr && reg_addr == 8'h05 |=> load_pulldown_en == $past(reg_wdata[3]))
    else $error("load pull-down does not follow run bit");
  pin_state_a: assert property (irq_pin_state == !irq_out_n)
    else $error("interrupt status differs from pin");
  one_pulse_a: assert property (fet_off_pulse |=> !fet_off_pulse)
    else $error("fet off pulse longer than one cycle");
  short_hold_a: assert property (
    fet_off_pulse |-> $past(short_cmp_raw, 4) && $past(short_cmp_raw, 8))
    else $error("fet off without persisting short");
  irq_cause_a: assert property (
    $fell(irq_out_n) |-> $past(chg_low_cmp_raw | chg_high_cmp_raw | load_cmp_raw | short_cmp_raw, 3))
    else $error("interrupt without comparator event");
  irq_clear_a: assert property (
    reg_wr && reg_addr == 8'h04 && reg_wdata == 8'h00 ##1
    reg_wr && reg_addr == 8'h05 && reg_wdata == 8'h00 |-> ##2 irq_out_n)
    else $error("interrupt stays after all flags cleared");
  rd_zero_a: assert property (
    reg_wr && reg_wdata == 8'h00 ##1 reg_rd && reg_addr == $past(reg_addr) |=> reg_rdata == 8'h00)
    else $error("stopped register reads nonzero");
  unmapped_a: assert property (
    reg_rd && reg_addr != 8'h04 && reg_addr != 8'h05 |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
endmodule
bind clds_detect clds_detect_properties chk_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .chg_low_cmp_raw(chg_low_cmp_raw), .chg_high_cmp_raw(chg_high_cmp_raw),
  .load_cmp_raw(load_cmp_raw), .short_cmp_raw(short_cmp_raw),
  .charger_pullup_en(charger_pullup_en), .load_pulldown_en(load_pulldown_en),
  .fet_off_pulse(fet_off_pulse), .irq_out_n(irq_out_n), .irq_pin_state(irq_pin_state));

// ==== verification/clds_detect_tb.sv ====
// self-checking bench for the charger, load and short detector
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons = comparisons + 1; if ((g) !== (e)) begin \
  err_count = err_count + 1; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module clds_detect_tb;
  reg        mclk;
  reg        rst;
  reg  [3:0] raw;
  wire [7:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire       reg_wr;
  wire       reg_rd;
  wire       pull_up;
  wire       pull_dn;
  wire       fet_off_pulse;
  wire       irq_out_n;
  wire       irq_pin_state;
  integer    err_count;
  integer    comparisons;
  integer    pulses;
  integer    exp_pulses;
  integer    seed;
  integer    i;
  integer    n;
  reg  [7:0] a;
  clds_detect #(.SHORT_DELAY_CYCLES(8)) dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .chg_low_cmp_raw(raw[0]), .chg_high_cmp_raw(raw[1]), .load_cmp_raw(raw[2]),
    .short_cmp_raw(raw[3]), .charger_pullup_en(pull_up), .load_pulldown_en(pull_dn),
    .fet_off_pulse(fet_off_pulse), .irq_out_n(irq_out_n), .irq_pin_state(irq_pin_state));
  clds_mcu_model mcu_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // ============================================================
  // helpers
  function [7:0] fld(input run, input en, input flag, input out, input [2:0] s);
    fld = {4'h0, run, en, flag, out} << s;
  endfunction
  task rdchk(input [7:0] ra, input [7:0] e);
    begin
      mcu_u.acc(2'b01, ra, 8'h00);
      `CHK(reg_rdata, e)
    end
  endtask
  task cmp_test(input integer c);
    reg [2:0] s;
    begin
      a = (c == 2) ? 8'h05 : 8'h04;
      s = (c == 1) ? 3'd4 : 3'd0;
      mcu_u.arm(a, 8'h08 << s, 8'h04 << s);
      rdchk(a, fld(1, 1, 0, 0, s));
      `CHK((c == 2) ? pull_dn : pull_up, 1'b1)
      raw[c] = 1'b1;
      mcu_u.idle(8);
      rdchk(a, fld(1, 1, 1, 1, s));
      `CHK(irq_pin_state, 1'b1)
      mcu_u.acc(2'b10, a, fld(1, 1, 1, 0, s));
      rdchk(a, fld(1, 1, 1, 1, s));
      mcu_u.acc(2'b10, a, fld(1, 1, 0, 1, s));
      mcu_u.idle(4);
      rdchk(a, fld(1, 1, 0, 1, s));
      `CHK(irq_out_n, 1'b1)
      raw[c] = 1'b0;
      mcu_u.acc(2'b10, a, fld(1, 0, 0, 0, s));
      mcu_u.idle(6);
      raw[c] = 1'b1;
      mcu_u.idle(8);
      rdchk(a, fld(1, 0, 0, 1, s));
      `CHK(irq_out_n, 1'b1)
      mcu_u.acc(2'b10, a, fld(0, 0, 0, 1, s));
      rdchk(a, 8'h00);
      `CHK((c == 2) ? pull_dn : pull_up, 1'b0)
      raw[c] = 1'b0;
      $display("test done: comparator %0d", c);
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ============================================================
  // clock, pulse counter, watchdog, sequence
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (fet_off_pulse === 1'b1) pulses <= pulses + 1;
  initial begin
    #50000;
    err_count = err_count + 1;
    results;
  end
  initial begin
    {seed, err_count, comparisons, pulses, exp_pulses, raw, rst} = {32'd97, 128'h0, 5'h01};
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
    rdchk(8'h04, 8'h00);
    rdchk(8'h05, 8'h00);
    for (i = 0; i < 3; i = i + 1) cmp_test(i);
    mcu_u.arm(8'h05, 8'h80, 8'h40);
    for (i = 0; i < 12; i = i + 1) begin
      n = ($random(seed) & 3) + ((i == 0 || $random(seed) & 1) ? 11 : 2);
      exp_pulses = exp_pulses + (n > 10);
      raw[3] = 1'b1;
      mcu_u.idle(n - 1);
      raw[3] = 1'b0;
      mcu_u.idle(12);
      rdchk(8'h05, {2'b11, (n > 10), 5'h00});
      `CHK(irq_out_n, n <= 10)
      mcu_u.acc(2'b10, 8'h05, 8'hC0);
    end
    mcu_u.acc(2'b10, 8'h05, 8'h00);
    raw[3] = 1'b1;
    mcu_u.idle(14);
    raw[3] = 1'b0;
    `CHK(pulses, exp_pulses)
    $display("test done: short detection");
    mcu_u.acc(2'b10, 8'h04, 8'h00);
    mcu_u.acc(2'b10, 8'h05, 8'h00);
    rdchk(8'h05, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      n = $random(seed);
      raw = n[3:0];
      a = $random(seed);
      if (a[7:1] == 7'h02) a = 8'h06;
      mcu_u.acc(2'b10, a, $random(seed));
      rdchk(a, 8'h00);
    end
    $display("test done: unmapped access");
    results;
  end
endmodule
